// *** pkg/io_space_pkg.sv ***
// constants for the i/o space decoder
package io_space_pkg;
  // address spaces
  localparam logic [7:0] IO_LAST = 8'h3F;
  localparam logic [7:0] BIT_LAST = 8'h1F;
  localparam logic [7:0] DATA_ALIAS = 8'h20;
  localparam logic [7:0] EXT_FIRST = 8'h60;
  localparam logic [7:0] EXT_LAST = 8'hFF;
  // register offsets (i/o addresses)
  localparam logic [5:0] PORT_B_PIN_LEVEL = 6'h03;
  localparam logic [5:0] PORT_B_DIRECTION = 6'h04;
  localparam logic [5:0] PORT_B_OUTPUT_LATCH = 6'h05;
  localparam logic [5:0] PORT_C_PIN_LEVEL = 6'h06;
  localparam logic [5:0] PORT_C_DIRECTION = 6'h07;
  localparam logic [5:0] PORT_C_OUTPUT_LATCH = 6'h08;
  localparam logic [5:0] PORT_D_PIN_LEVEL = 6'h09;
  localparam logic [5:0] PORT_D_DIRECTION = 6'h0A;
  localparam logic [5:0] PORT_D_OUTPUT_LATCH = 6'h0B;
  localparam logic [5:0] TIMER0_FLAGS = 6'h15;
  localparam logic [5:0] TIMER1_FLAGS = 6'h16;
  localparam logic [5:0] TIMER2_FLAGS = 6'h17;
  localparam logic [5:0] PIN_CHANGE_FLAGS = 6'h1B;
  // implemented bit masks, others read zero
  localparam logic [7:0] PORT_C_MASK = 8'h7F;
  localparam logic [7:0] TIMER0_MASK = 8'h07;
  localparam logic [7:0] TIMER1_MASK = 8'h27;
  localparam logic [7:0] TIMER2_MASK = 8'h07;
  localparam logic [7:0] PIN_CHANGE_MASK = 8'h07;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  // operation codes on the core side
  typedef enum logic [2:0] {
    OP_NONE,
    OP_IO_READ,
    OP_IO_WRITE,
    OP_DATA_FETCH,
    OP_DATA_PUT,
    OP_SET_BIT,
    OP_CLEAR_BIT,
    OP_SKIP_TEST
  } io_op_e;
endpackage

// *** rtl/io_space_address_decoder.sv ***
// i/o space decoder and peripheral register bank
`timescale 1ns/100ps
`default_nettype none
module io_space_address_decoder #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // core access port
  input wire io_space_pkg::io_op_e i_op,
  input wire logic [7:0] i_addr,
  input wire logic [2:0] i_bit,
  input wire logic [WIDTH-1:0] i_wdata,
  output logic [WIDTH-1:0] o_rdata,
  output logic o_bit_set,
  output logic o_ext_sel,
  output logic o_bit_refused,
  // port pins
  input wire logic [WIDTH-1:0] i_port_b_pins,
  input wire logic [WIDTH-1:0] i_port_c_pins,
  input wire logic [WIDTH-1:0] i_port_d_pins,
  output logic [WIDTH-1:0] o_port_b_dir,
  output logic [WIDTH-1:0] o_port_b_out,
  output logic [WIDTH-1:0] o_port_c_dir,
  output logic [WIDTH-1:0] o_port_c_out,
  output logic [WIDTH-1:0] o_port_d_dir,
  output logic [WIDTH-1:0] o_port_d_out,
  // flag set events from peripherals
  input wire logic [WIDTH-1:0] i_timer0_evt,
  input wire logic [WIDTH-1:0] i_timer1_evt,
  input wire logic [WIDTH-1:0] i_timer2_evt,
  input wire logic [WIDTH-1:0] i_pin_change_evt,
  output logic [WIDTH-1:0] o_timer0_flags,
  output logic [WIDTH-1:0] o_timer1_flags,
  output logic [WIDTH-1:0] o_timer2_flags,
  output logic [WIDTH-1:0] o_pin_change_flags
);
  localparam int NREG = 13;

  // write-one-to-clear then set; set wins over clear
  function automatic logic [WIDTH-1:0] flag_next(input logic [WIDTH-1:0] cur,
    input logic [WIDTH-1:0] clr, input logic [WIDTH-1:0] evt, input logic [WIDTH-1:0] msk);
    flag_next = ((cur & ~clr) | evt) & msk;
  endfunction

  logic [WIDTH-1:0] pin_b;
  logic [WIDTH-1:0] pin_c;
  logic [WIDTH-1:0] pin_d;
  pin_sync #(.WIDTH(WIDTH)) u_sync_b (.i_mclk(i_mclk), .i_srst(i_srst),
    .i_async(i_port_b_pins), .o_sync(pin_b));
  pin_sync #(.WIDTH(WIDTH)) u_sync_c (.i_mclk(i_mclk), .i_srst(i_srst),
    .i_async(i_port_c_pins), .o_sync(pin_c));
  pin_sync #(.WIDTH(WIDTH)) u_sync_d (.i_mclk(i_mclk), .i_srst(i_srst),
    .i_async(i_port_d_pins), .o_sync(pin_d));

  logic [WIDTH-1:0] b_dir_r, b_out_r, c_dir_r, c_out_r, d_dir_r, d_out_r;
  logic [WIDTH-1:0] t0_r, t1_r, t2_r, pc_r;
  logic [WIDTH-1:0] rdata_r;
  logic bit_set_r, ext_r, refused_r;

  // dedicated i/o instructions see 0x00..0x3F directly
  wire io_op = (i_op == io_space_pkg::OP_IO_READ) || (i_op == io_space_pkg::OP_IO_WRITE);
  wire data_op = (i_op == io_space_pkg::OP_DATA_FETCH) || (i_op == io_space_pkg::OP_DATA_PUT);
  wire bit_op = (i_op == io_space_pkg::OP_SET_BIT) || (i_op == io_space_pkg::OP_CLEAR_BIT)
    || (i_op == io_space_pkg::OP_SKIP_TEST);
  wire io_in_range = io_op && (i_addr <= io_space_pkg::IO_LAST);
  // data space alias at i/o address plus 0x20
  wire data_in_io = data_op && (i_addr >= io_space_pkg::DATA_ALIAS)
    && (i_addr < io_space_pkg::EXT_FIRST);
  wire [7:0] data_io_addr = i_addr - io_space_pkg::DATA_ALIAS;
  // extended region only through data ops
  wire ext_hit = data_op && (i_addr >= io_space_pkg::EXT_FIRST);
  // bit ops only in the low 32 locations
  wire bit_ok = bit_op && (i_addr <= io_space_pkg::BIT_LAST);
  wire sel_valid = io_in_range || data_in_io || bit_ok;
  wire [5:0] sel = data_in_io ? data_io_addr[5:0] : i_addr[5:0];
  wire is_write = (i_op == io_space_pkg::OP_IO_WRITE) || (i_op == io_space_pkg::OP_DATA_PUT);
  wire is_read = (i_op == io_space_pkg::OP_IO_READ) || (i_op == io_space_pkg::OP_DATA_FETCH)
    || (i_op == io_space_pkg::OP_SKIP_TEST);
  wire [WIDTH-1:0] bit_mask = WIDTH'(1) << i_bit;

  // unmapped locations and reserved bits read as zero
  logic [WIDTH-1:0] cur;
  always_comb
  begin
    cur = '0;
    if (sel_valid)
    begin
      unique case (sel)
        io_space_pkg::PORT_B_PIN_LEVEL: cur = pin_b;
        io_space_pkg::PORT_B_DIRECTION: cur = b_dir_r;
        io_space_pkg::PORT_B_OUTPUT_LATCH: cur = b_out_r;
        io_space_pkg::PORT_C_PIN_LEVEL: cur = pin_c & io_space_pkg::PORT_C_MASK;
        io_space_pkg::PORT_C_DIRECTION: cur = c_dir_r;
        io_space_pkg::PORT_C_OUTPUT_LATCH: cur = c_out_r;
        io_space_pkg::PORT_D_PIN_LEVEL: cur = pin_d;
        io_space_pkg::PORT_D_DIRECTION: cur = d_dir_r;
        io_space_pkg::PORT_D_OUTPUT_LATCH: cur = d_out_r;
        io_space_pkg::TIMER0_FLAGS: cur = t0_r;
        io_space_pkg::TIMER1_FLAGS: cur = t1_r;
        io_space_pkg::TIMER2_FLAGS: cur = t2_r;
        io_space_pkg::PIN_CHANGE_FLAGS: cur = pc_r;
        default: cur = '0;
      endcase
    end
  end

  // write data per op; set-bit on flag regs clears only the addressed bit, clear-bit clears none
  wire do_set = bit_ok && (i_op == io_space_pkg::OP_SET_BIT);
  wire do_clr = bit_ok && (i_op == io_space_pkg::OP_CLEAR_BIT);
  wire wr_any = (is_write && sel_valid) || do_set || do_clr;
  wire [WIDTH-1:0] plain_wval = do_set ? (cur | bit_mask) : do_clr ? (cur & ~bit_mask) : i_wdata;
  // a set-bit on a flag reg writes one only to its bit
  wire [WIDTH-1:0] flag_clr = do_set ? bit_mask : (do_clr ? '0 : i_wdata);
  function automatic logic hit(input logic [5:0] a);
    hit = wr_any && (sel == a);
  endfunction

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      b_dir_r <= io_space_pkg::RESET_VALUE;
      b_out_r <= io_space_pkg::RESET_VALUE;
      c_dir_r <= io_space_pkg::RESET_VALUE;
      c_out_r <= io_space_pkg::RESET_VALUE;
      d_dir_r <= io_space_pkg::RESET_VALUE;
      d_out_r <= io_space_pkg::RESET_VALUE;
    end
    else
    begin
      if (hit(io_space_pkg::PORT_B_DIRECTION)) b_dir_r <= plain_wval;
      if (hit(io_space_pkg::PORT_B_OUTPUT_LATCH)) b_out_r <= plain_wval;
      if (hit(io_space_pkg::PORT_C_DIRECTION)) c_dir_r <= plain_wval & io_space_pkg::PORT_C_MASK;
      if (hit(io_space_pkg::PORT_C_OUTPUT_LATCH))
        c_out_r <= plain_wval & io_space_pkg::PORT_C_MASK;
      if (hit(io_space_pkg::PORT_D_DIRECTION)) d_dir_r <= plain_wval;
      if (hit(io_space_pkg::PORT_D_OUTPUT_LATCH)) d_out_r <= plain_wval;
    end
  end

  // write-one-to-clear flags, events win over clears
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      t0_r <= io_space_pkg::RESET_VALUE;
      t1_r <= io_space_pkg::RESET_VALUE;
      t2_r <= io_space_pkg::RESET_VALUE;
      pc_r <= io_space_pkg::RESET_VALUE;
    end
    else
    begin
      t0_r <= flag_next(t0_r, hit(io_space_pkg::TIMER0_FLAGS) ? flag_clr : '0,
        i_timer0_evt, io_space_pkg::TIMER0_MASK);
      t1_r <= flag_next(t1_r, hit(io_space_pkg::TIMER1_FLAGS) ? flag_clr : '0,
        i_timer1_evt, io_space_pkg::TIMER1_MASK);
      t2_r <= flag_next(t2_r, hit(io_space_pkg::TIMER2_FLAGS) ? flag_clr : '0,
        i_timer2_evt, io_space_pkg::TIMER2_MASK);
      pc_r <= flag_next(pc_r, hit(io_space_pkg::PIN_CHANGE_FLAGS) ? flag_clr : '0,
        i_pin_change_evt, io_space_pkg::PIN_CHANGE_MASK);
    end
  end

  // read path registered; skip test returns selected bit
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      rdata_r <= '0;
      bit_set_r <= 1'b0;
      ext_r <= 1'b0;
      refused_r <= 1'b0;
    end
    else
    begin
      rdata_r <= (is_read && sel_valid) ? cur : '0;
      bit_set_r <= bit_ok && (i_op == io_space_pkg::OP_SKIP_TEST) && cur[i_bit];
      ext_r <= ext_hit;
      refused_r <= bit_op && !bit_ok;
    end
  end

  assign o_rdata = rdata_r;
  assign o_bit_set = bit_set_r;
  assign o_ext_sel = ext_r;
  assign o_bit_refused = refused_r;
  assign o_port_b_dir = b_dir_r;
  assign o_port_b_out = b_out_r;
  assign o_port_c_dir = c_dir_r;
  assign o_port_c_out = c_out_r;
  assign o_port_d_dir = d_dir_r;
  assign o_port_d_out = d_out_r;
  assign o_timer0_flags = t0_r;
  assign o_timer1_flags = t1_r;
  assign o_timer2_flags = t2_r;
  assign o_pin_change_flags = pc_r;

  // written one clears a flag unless an event arrives
  w1c_clear_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (is_write && sel_valid && sel == io_space_pkg::TIMER0_FLAGS && i_wdata[0] && !i_timer0_evt[0])
    |=> !t0_r[0]) else $error("flag not cleared by written one");
  w1c_keep_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (is_write && sel_valid && sel == io_space_pkg::TIMER1_FLAGS && !i_wdata[0] && t1_r[0])
    |=> t1_r[0]) else $error("flag lost on written zero");
  bit_only_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (do_set && sel == io_space_pkg::TIMER2_FLAGS && i_bit != 3'h2 && t2_r[2])
    |=> t2_r[2]) else $error("single-bit op cleared another flag");
  // high bit ops refused and inert
  bit_range_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (bit_op && i_addr > io_space_pkg::BIT_LAST) |=> (o_bit_refused && $stable(b_out_r)))
    else $error("bit op accepted above low range");
  // io op never selects extended region
  ext_only_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    io_op |=> !o_ext_sel) else $error("io op reached extended region");
  // data alias reads same as io read
  alias_read_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_op == io_space_pkg::OP_DATA_FETCH && i_addr == 8'h25) |=> (o_rdata == b_out_r))
    else $error("data alias read mismatch");
  io_read_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_op == io_space_pkg::OP_IO_READ && i_addr == 8'h04) ##1 1'b1 |-> (o_rdata == b_dir_r))
    else $error("io read mismatch");
  rsvd_zero_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_op == io_space_pkg::OP_IO_READ && i_addr == 8'h00) |=> (o_rdata == '0))
    else $error("reserved location read nonzero");
  skip_test_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_op == io_space_pkg::OP_SKIP_TEST && i_addr == 8'h04 && i_bit == 3'h3 && b_dir_r[3])
    |=> o_bit_set) else $error("skip test lost set bit");
  set_bit_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (do_set && sel == io_space_pkg::PORT_B_DIRECTION && i_bit == 3'h3) |=> b_dir_r[3])
    else $error("set-bit did not set");
endmodule // io_space_address_decoder
`default_nettype wire

// *** rtl/pin_sync.sv ***
// two-flop synchroniser for a bus of pin levels
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // async in, synced out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end
  assign o_sync = sync_r;
endmodule // pin_sync
`default_nettype wire

// *** tb/core_model.sv ***
// core-side model issuing i/o, data and bit operations
`timescale 1ns/100ps
`default_nettype none
module core_model (
  // clock
  input wire logic i_mclk,
  // request
  output var io_space_pkg::io_op_e o_op,
  output logic [7:0] o_addr,
  output logic [2:0] o_bit,
  output logic [7:0] o_wdata,
  // answer
  input wire logic [7:0] i_rdata,
  input wire logic i_bit_set,
  input wire logic i_ext_sel,
  input wire logic i_bit_refused
);
  initial
  begin
    o_op = io_space_pkg::OP_NONE;
    o_addr = 8'h00;
    o_bit = 3'h0;
    o_wdata = 8'h00;
  end
  // one op held to its taking edge, answer read once it settles
  task automatic x(input io_space_pkg::io_op_e op, input logic [7:0] a,
    input logic [2:0] b, input logic [7:0] d, output logic [10:0] ans);
    @(posedge i_mclk);
    o_op <= op;
    o_addr <= a;
    o_bit <= b;
    o_wdata <= d;
    @(posedge i_mclk);
    o_op <= io_space_pkg::OP_NONE;
    // released address and data lines show the inverse, so stale data cannot pass
    o_addr <= ~a;
    o_wdata <= ~d;
    #1;
    ans = {i_bit_refused, i_ext_sel, i_bit_set, i_rdata};
  endtask
endmodule // core_model
`default_nettype wire

// *** tb/io_space_address_decoder_tb.sv ***
// self-checking bench for the i/o space decoder
`timescale 1ns/100ps
`default_nettype none
module io_space_address_decoder_tb;
  localparam io_space_pkg::io_op_e RD = io_space_pkg::OP_IO_READ;
  localparam io_space_pkg::io_op_e WR = io_space_pkg::OP_IO_WRITE;
  localparam io_space_pkg::io_op_e DF = io_space_pkg::OP_DATA_FETCH;
  localparam io_space_pkg::io_op_e DP = io_space_pkg::OP_DATA_PUT;
  localparam io_space_pkg::io_op_e SB = io_space_pkg::OP_SET_BIT;
  localparam io_space_pkg::io_op_e CB = io_space_pkg::OP_CLEAR_BIT;
  localparam io_space_pkg::io_op_e SK = io_space_pkg::OP_SKIP_TEST;
  localparam logic [7:0] PA [6] = '{8'h04, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0B};
  localparam logic [7:0] FA [4] = '{8'h15, 8'h16, 8'h17, 8'h1B};
  localparam logic [7:0] FM [4] = '{8'h07, 8'h27, 8'h07, 8'h07};
  localparam logic [7:0] RA [6] = '{8'h00, 8'h02, 8'h0C, 8'h10, 8'h18, 8'h1A};
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic [7:0] pins [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] evt [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [10:0] ans;
  wire [7:0] prt [6];
  wire [7:0] flg [4];
  io_space_pkg::io_op_e op;
  wire [7:0] addr;
  wire [7:0] wdata;
  wire [7:0] rdata;
  wire [2:0] bsel;
  wire bit_set;
  wire ext_sel;
  wire refused;
  int failures = 0;
  int checked = 0;
  int cycles = 0;

  always #2 i_mclk = ~i_mclk;

  core_model core_model_i (.i_mclk(i_mclk), .o_op(op), .o_addr(addr), .o_bit(bsel),
    .o_wdata(wdata), .i_rdata(rdata), .i_bit_set(bit_set), .i_ext_sel(ext_sel),
    .i_bit_refused(refused));

  io_space_address_decoder io_space_address_decoder_i (.i_mclk(i_mclk), .i_srst(i_srst),
    .i_op(op), .i_addr(addr), .i_bit(bsel), .i_wdata(wdata), .o_rdata(rdata),
    .o_bit_set(bit_set), .o_ext_sel(ext_sel), .o_bit_refused(refused),
    .i_port_b_pins(pins[0]), .i_port_c_pins(pins[1]), .i_port_d_pins(pins[2]),
    .o_port_b_dir(prt[0]), .o_port_b_out(prt[1]), .o_port_c_dir(prt[2]),
    .o_port_c_out(prt[3]), .o_port_d_dir(prt[4]), .o_port_d_out(prt[5]),
    .i_timer0_evt(evt[0]), .i_timer1_evt(evt[1]), .i_timer2_evt(evt[2]),
    .i_pin_change_evt(evt[3]), .o_timer0_flags(flg[0]), .o_timer1_flags(flg[1]),
    .o_timer2_flags(flg[2]), .o_pin_change_flags(flg[3]));

  task automatic final_report;
    if (failures == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic pulse(input int k, input logic [7:0] v);
    @(posedge i_mclk);
    evt[k] <= v;
    @(posedge i_mclk);
    evt[k] <= 8'h00;
    #1;
  endtask

  task automatic t_ports;
    logic [7:0] e;
    for (int k = 0; k < 6; k++)
    begin
      core_model_i.x(RD, PA[k], 3'h0, 8'h00, ans);
      chk("port reset", 8'h00, ans[7:0]);
      e = (k == 2 || k == 3) ? 8'h25 : 8'hA5;
      core_model_i.x(WR, PA[k], 3'h0, e, ans);
      chk("port out", e, prt[k]);
      core_model_i.x(DF, PA[k] + 8'h20, 3'h0, 8'h00, ans);
      chk("alias read", e, ans[7:0]);
    end
  endtask

  task automatic t_bits;
    core_model_i.x(SB, 8'h04, 3'h3, 8'h00, ans);
    chk("set bit", 8'hAD, prt[0]);
    core_model_i.x(SK, 8'h04, 3'h3, 8'h00, ans);
    chk("skip set", 8'h01, {7'h00, ans[8]});
    core_model_i.x(SK, 8'h04, 3'h1, 8'h00, ans);
    chk("skip clear", 8'h00, {7'h00, ans[8]});
    core_model_i.x(CB, 8'h04, 3'h0, 8'h00, ans);
    chk("clear bit", 8'hAC, prt[0]);
    core_model_i.x(SB, 8'h24, 3'h1, 8'h00, ans);
    chk("bit refused", 8'h01, {7'h00, ans[10]});
    chk("refused no write", 8'hAC, prt[0]);
    core_model_i.x(SK, 8'h1F, 3'h0, 8'h00, ans);
    chk("bit edge", 8'h00, {7'h00, ans[10]});
  endtask

  task automatic t_ext;
    core_model_i.x(DF, 8'h60, 3'h0, 8'h00, ans);
    chk("ext low", 8'h01, {7'h00, ans[9]});
    core_model_i.x(DP, 8'hFF, 3'h0, 8'h55, ans);
    chk("ext high", 8'h01, {7'h00, ans[9]});
    core_model_i.x(RD, 8'h60, 3'h0, 8'h00, ans);
    chk("io not ext", 8'h00, {7'h00, ans[9]});
    core_model_i.x(DF, 8'h5F, 3'h0, 8'h00, ans);
    chk("alias top", 8'h00, {7'h00, ans[9]});
    core_model_i.x(DF, 8'h05, 3'h0, 8'h00, ans);
    chk("below alias", 8'h00, ans[7:0]);
    core_model_i.x(RD, 8'h45, 3'h0, 8'h00, ans);
    chk("io over", 8'h00, ans[7:0]);
  endtask

  task automatic t_flags;
    for (int k = 0; k < 4; k++)
    begin
      chk("flag reset", 8'h00, flg[k]);
      pulse(k, 8'hFF);
      chk("flag set", FM[k], flg[k]);
      core_model_i.x(WR, FA[k], 3'h0, 8'h00, ans);
      chk("zero keeps", FM[k], flg[k]);
      core_model_i.x(WR, FA[k], 3'h0, 8'h01, ans);
      chk("one clears", FM[k] & 8'hFE, flg[k]);
      core_model_i.x(SB, FA[k], 3'h1, 8'h00, ans);
      chk("set bit only", FM[k] & 8'hFC, flg[k]);
      core_model_i.x(CB, FA[k], 3'h2, 8'h00, ans);
      chk("clear bit none", FM[k] & 8'hFC, flg[k]);
      core_model_i.x(DP, FA[k] + 8'h20, 3'h0, FM[k], ans);
      chk("alias clear", 8'h00, flg[k]);
    end
  endtask

  task automatic t_reserved;
    @(posedge i_mclk);
    pins[0] <= 8'h5A;
    pins[1] <= 8'hFF;
    pins[2] <= 8'h3C;
    repeat (3) @(posedge i_mclk);
    core_model_i.x(RD, 8'h03, 3'h0, 8'h00, ans);
    chk("pin b", 8'h5A, ans[7:0]);
    core_model_i.x(DF, 8'h26, 3'h0, 8'h00, ans);
    chk("pin c mask", 8'h7F, ans[7:0]);
    core_model_i.x(DF, 8'h29, 3'h0, 8'h00, ans);
    chk("pin d", 8'h3C, ans[7:0]);
    foreach (RA[k])
    begin
      core_model_i.x(RD, RA[k], 3'h0, 8'h00, ans);
      chk("reserved", 8'h00, ans[7:0]);
    end
  endtask

  // event and written one in one cycle, then a reset in mid-run
  task automatic t_race;
    fork
      pulse(0, 8'h01);
      core_model_i.x(WR, FA[0], 3'h0, 8'h01, ans);
    join
    chk("set wins", 8'h01, flg[0]);
    @(posedge i_mclk);
    i_srst <= 1'b1;
    core_model_i.x(WR, PA[0], 3'h0, 8'hFF, ans);
    @(posedge i_mclk);
    i_srst <= 1'b0;
    chk("reset flags", 8'h00, flg[0]);
    chk("reset port", 8'h00, prt[0]);
  endtask

  // ceiling well above the under two hundred cycles the run needs
  always @(posedge i_mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      failures++;
      final_report;
    end
  end

  initial
  begin
    repeat (10) @(posedge i_mclk);
    i_srst <= 1'b0;
    t_ports;
    t_bits;
    t_ext;
    t_flags;
    t_race;
    t_reserved;
    final_report;
  end
endmodule // io_space_address_decoder_tb
`default_nettype wire
